/* testbench/ssic_decoder_asserts.sv */
// Port-level checker for the inspection command decoder.
// Bound into every ssic_decoder; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ssic_decoder_chk #(
	parameter ssic_pkg::ssic_cnt_t	BIT_TIMEOUT = 16'h2710,
	parameter ssic_pkg::ssic_cnt_t	GAP_TIMEOUT = 16'hC350
) (
	input wire logic	ref_clk,
	input wire logic	nrst,
	input wire logic	line_in,
	input wire logic	tooth_present,
	input wire logic	entry_allowed,
	input wire logic	line_oe,
	input wire logic	test_mode_active,
	input wire logic	protocol_error
);
	import ssic_pkg::*;
	// ==========================================================
	// Helpers
	logic	up_q;
	logic	started_q;
	logic [15:0]	low_q;
	wire logic	ext_low = !line_in && !line_oe;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			up_q <= 1'b0;
			started_q <= 1'b0;
			low_q <= 16'h0000;
		end else begin
			up_q <= 1'b1;
			started_q <= started_q | ext_low;
			low_q <= ext_low ? low_q + 16'h0001 : 16'h0000;
		end
	end
	// ==========================================================
	// Properties
	a_normal_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
		up_q && !started_q |-> line_oe == !$past(tooth_present))
		else $error("line not following wheel");
	a_error_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
		protocol_error |=> protocol_error) else $error("error flag dropped");
	a_error_low: assert property (@(posedge ref_clk) disable iff (!nrst)
		$past(protocol_error) |-> line_oe) else $error("line released after error");
	a_bit_timeout: assert property (@(posedge ref_clk) disable iff (!nrst)
		low_q > BIT_TIMEOUT + 4 |-> protocol_error) else $error("long low not refused");
	a_mode_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
		test_mode_active |=> test_mode_active) else $error("test mode dropped");
	a_mode_entry: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(test_mode_active) |-> started_q && $past(entry_allowed))
		else $error("test mode without command");
	a_reply_start: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(line_oe) && started_q && !protocol_error |-> $past(line_in))
		else $error("reply not after mark");
	a_reply_len: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(line_oe) && started_q && !protocol_error |-> line_oe [*8])
		else $error("reply too short");
endmodule
bind ssic_decoder ssic_decoder_chk #(.BIT_TIMEOUT(BIT_TIMEOUT), .GAP_TIMEOUT(GAP_TIMEOUT)) u_chk (
	.ref_clk(ref_clk), .nrst(nrst), .line_in(line_in), .tooth_present(tooth_present),
	.entry_allowed(entry_allowed), .line_oe(line_oe), .test_mode_active(test_mode_active),
	.protocol_error(protocol_error));
`default_nettype wire

/* testbench/ssic_master.sv */
// Master model for the shared pulled-up inspection line.
// Drives on the falling clock edge; line is the wired level.
`timescale 1ns/10ps
`default_nettype none
module ssic_master (
	input wire logic	ref_clk,
	input wire logic	line,
	output var logic	pull_q
);
	initial pull_q = 1'b0;
	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Low twice the release for a zero; long pause lets the reply end
	task automatic send_bit(input logic b, output logic rb);
		int t1;
		t1 = b ? 40 : 80;
		pull_q = 1'b1;
		wait_n(t1);
		pull_q = 1'b0;
		wait_n(120 - t1);
		pull_q = 1'b1;
		wait_n(3);
		pull_q = 1'b0;
		wait_n(40);
		rb = line;
		wait_n(160);
	endtask
	// MSB first; first bit tells command from data word
	task automatic send_word(input logic [15:0] w, input int n, output logic [15:0] rw);
		logic b;
		rw = 16'h0000;
		for (int i = n - 1; i >= 0; i--) begin
			send_bit(w[i], b);
			rw[i] = b;
		end
	endtask
	task automatic hang(input int n);
		pull_q = 1'b1;
		wait_n(n);
		pull_q = 1'b0;
		wait_n(5);
	endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the inspection command decoder.
// Master model on a pulled-up line; short timeouts for speed.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ssic_pkg::*;
	localparam ssic_cnt_t	BT = 16'h0190;
	// Negative tracking value shows the sign is kept
	localparam logic [15:0]	EV [4] = '{16'h1234, 16'h7ABC, 16'h4567, 16'hFE0C};
	localparam logic [7:0]	RC [4] = '{CMD_READ_MIN, CMD_READ_MAX, CMD_READ_THR, CMD_READ_IIR};
	logic	ref_clk;
	logic	nrst;
	logic	tooth;
	logic	entry;
	logic [15:0]	v [4];
	logic [15:0]	r;
	wire logic	oe, lout, tm, perr, pull;
	wire logic	line = ~(pull | oe);
	int	miscompares = 0;
	int	cmp_count = 0;
	ssic_decoder #(.BIT_TIMEOUT(BT), .GAP_TIMEOUT(16'h07D0)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .line_in(line), .tooth_present(tooth),
		.entry_allowed(entry), .min_value(v[0]), .max_value(v[1]),
		.threshold_value(v[2]), .tracking_value(v[3]), .line_out(lout),
		.line_oe(oe), .test_mode_active(tm), .protocol_error(perr));
	ssic_master u_m (.ref_clk(ref_clk), .line(line), .pull_q(pull));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
		cmp_count++;
		if (seen !== ex) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_normal;
		tooth = 1'b0;
		u_m.wait_n(3);
		check("oe notch", oe, 1'b1);
		tooth = 1'b1;
		u_m.wait_n(3);
		check("oe tooth", oe, 1'b0);
		check("line out", lout, 1'b0);
	endtask
	task automatic t_cmd(input logic [7:0] c, input logic m);
		u_m.send_word({8'h00, c}, 8, r);
		check("echo", r[7:0], c);
		check("mode", tm, m);
	endtask
	// Slot changes mid-word; the snapshot must not follow it
	task automatic t_read(input int i);
		t_cmd(RC[i], 1'b1);
		fork
			u_m.send_word(16'h0000, 16, r);
			begin
				u_m.wait_n(400);
				v[i] = ~EV[i];
			end
		join
		v[i] = EV[i];
		check("value", r, EV[i]);
	endtask
	task automatic t_error;
		u_m.hang(BT + 16'h0014);
		check("error", perr, 1'b1);
		u_m.send_word({8'h00, CMD_ACTIVATE}, 8, r);
		check("dead reply", r, 16'h0000);
		check("held low", oe, 1'b1);
	endtask
	// Power-on restart is the only way out of the error state
	task automatic t_restart;
		nrst = 1'b0;
		u_m.wait_n(2);
		nrst = 1'b1;
		u_m.wait_n(3);
		check("error cleared", perr, 1'b0);
		check("mode cleared", tm, 1'b0);
		check("oe released", oe, 1'b0);
		t_cmd(CMD_ACTIVATE, 1'b1);
	endtask
	// ==========================================================
	// Sequence
	initial begin
		nrst = 1'b0;
		tooth = 1'b1;
		entry = 1'b0;
		v = EV;
		u_m.wait_n(2);
		nrst = 1'b1;
		u_m.wait_n(3);
		t_normal();
		t_cmd(CMD_READ_MIN, 1'b0);
		t_cmd(CMD_ACTIVATE, 1'b0);
		entry = 1'b1;
		t_cmd(CMD_ACTIVATE, 1'b1);
		for (int i = 0; i < 4; i++) begin
			t_read(i);
		end
		t_error();
		t_restart();
		end_of_test();
	end
	initial begin
		u_m.wait_n(60000);
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire

/* verilog/ssic_decoder.sv */
// Command decoder for the single-wire inspection link on the open-drain speed output.
// Assumes line_in is the line comparator, synchronous to ref_clk; nrst is power-on only.
`timescale 1ns/10ps
`default_nettype none

module ssic_decoder #(
	parameter ssic_pkg::ssic_cnt_t BIT_TIMEOUT = ssic_pkg::ssic_cnt_t'(ssic_pkg::BIT_TIMEOUT_CYC),
	parameter ssic_pkg::ssic_cnt_t GAP_TIMEOUT = ssic_pkg::ssic_cnt_t'(ssic_pkg::GAP_TIMEOUT_CYC)
) (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic                          line_in,
	input  wire logic                          tooth_present,
	input  wire logic                          entry_allowed,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  min_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  max_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  threshold_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  tracking_value,
	output var  logic                          line_out,
	output var  logic                          line_oe,
	output var  logic                          test_mode_active,
	output var  logic                          protocol_error
);
	import ssic_pkg::*;

	// ==========================================================
	// Declarations
	ssic_state_e          state_q;
	ssic_state_e          state_d;
	ssic_cnt_t            cnt_q;
	ssic_cnt_t            t1_q;
	ssic_cnt_t            t2_q;
	ssic_cnt_t            reply_len_q;
	logic [CMD_BITS-2:0]  shift_q;
	logic [BITCNT_W-1:0]  bit_cnt_q;
	logic                 is_cmd_q;
	logic                 resp_q;
	logic                 sess_q;
	logic                 test_mode_q;
	logic [1:0]           sel_q;
	logic                 sel_valid_q;
	logic                 line_q;
	logic [VALUE_W-1:0]   rd_data;

	wire                  fall;
	wire                  rise;
	wire                  rx_bit;
	wire                  is_cmd_eff;
	wire [BITCNT_W-1:0]   frame_last;
	wire                  last_bit;
	wire [CMD_BITS-1:0]   cmd_word;
	wire [3:0]            bit_pos;
	wire                  reply_bit;
	wire ssic_cnt_t       diff;
	wire                  bit_done;
	wire                  timed_out;
	wire                  gap_out;
	wire                  capture;
	wire                  cmd_done;
	wire                  is_read;
	wire [1:0]            read_sel;

	// ==========================================================
	// Read command decode
	function automatic logic [2:0] read_decode(input logic [CMD_BITS-1:0] code);
		logic [2:0] r;
		r = 3'h0;
		unique case (code)
			CMD_READ_MIN: r = {1'b1, SEL_MIN};
			CMD_READ_MAX: r = {1'b1, SEL_MAX};
			CMD_READ_THR: r = {1'b1, SEL_THR};
			CMD_READ_IIR: r = {1'b1, SEL_IIR};
			default:      r = 3'h0;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Bit level decode
	assign fall = line_q & ~line_in;
	assign rise = ~line_q & line_in;
	// Longer release than low phase means the master sent a one
	assign rx_bit = (t2_q > t1_q);
	assign is_cmd_eff = (bit_cnt_q == 5'h00) ? rx_bit : is_cmd_q;
	assign frame_last = is_cmd_eff ? BITCNT_W'(CMD_BITS - 1) : BITCNT_W'(DATA_BITS - 1);
	assign last_bit = (bit_cnt_q == frame_last);
	assign cmd_word = {shift_q, rx_bit};
	assign bit_pos = 4'hF - bit_cnt_q[3:0];
	assign reply_bit = (!is_cmd_eff && test_mode_q && sel_valid_q) ?
		rd_data[bit_pos] : rx_bit;
	assign diff = (t1_q > t2_q) ? (t1_q - t2_q) : (t2_q - t1_q);
	assign bit_done = (state_q == ST_MARK) && rise;
	assign timed_out = (cnt_q >= BIT_TIMEOUT);
	assign gap_out = (bit_cnt_q != 5'h00) && (cnt_q >= GAP_TIMEOUT);
	assign capture = (state_q == ST_IDLE) && fall && !line_oe && (bit_cnt_q == 5'h00);
	assign cmd_done = bit_done && last_bit && is_cmd_eff;
	assign {is_read, read_sel} = read_decode(cmd_word);

	// ==========================================================
	// Bit receiver
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (fall && !line_oe) begin
					state_d = ST_LOW;
				end else if (gap_out) begin
					state_d = ST_ERROR;
				end
			end
			ST_LOW: begin
				if (rise) begin
					state_d = ST_HIGH;
				end else if (timed_out) begin
					state_d = ST_ERROR;
				end
			end
			ST_HIGH: begin
				if (fall) begin
					state_d = ST_MARK;
				end else if (timed_out) begin
					state_d = ST_ERROR;
				end
			end
			ST_MARK: begin
				if (rise) begin
					state_d = ST_REPLY;
				end else if (timed_out) begin
					state_d = ST_ERROR;
				end
			end
			ST_REPLY: begin
				if (cnt_q >= reply_len_q) begin
					state_d = ST_IDLE;
				end
			end
			ST_ERROR: begin
				state_d = ST_ERROR;
			end
			default: begin
				state_d = ST_ERROR;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			line_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			line_q  <= line_in;
		end
	end

	// Phase counter restarts on every state change
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 16'h0000;
		end else if (state_d != state_q) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q != 16'hFFFF) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// ==========================================================
	// Phase times and reply
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			t1_q        <= 16'h0000;
			t2_q        <= 16'h0000;
			reply_len_q <= 16'h0000;
			resp_q      <= 1'b1;
		end else begin
			if (state_q == ST_LOW && rise) begin
				t1_q <= cnt_q;
			end
			if (state_q == ST_HIGH && fall) begin
				t2_q <= cnt_q;
			end
			// Hold a little past the master's sample point but well inside the pause
			if (bit_done) begin
				reply_len_q <= diff + ssic_cnt_t'(REPLY_EXTRA_CYC);
				resp_q      <= reply_bit;
			end
		end
	end

	// ==========================================================
	// Frame and command state
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shift_q   <= 7'h00;
			bit_cnt_q <= 5'h00;
			is_cmd_q  <= 1'b0;
			sess_q    <= 1'b0;
		end else begin
			if (capture) begin
				sess_q <= 1'b1;
			end
			if (bit_done) begin
				shift_q   <= cmd_word[CMD_BITS-2:0];
				is_cmd_q  <= is_cmd_eff;
				bit_cnt_q <= last_bit ? 5'h00 : bit_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			test_mode_q <= 1'b0;
			sel_q       <= SEL_MIN;
			sel_valid_q <= 1'b0;
		end else if (cmd_done) begin
			if (cmd_word == CMD_ACTIVATE && entry_allowed) begin
				test_mode_q <= 1'b1;
			end
			// Reads only take effect once test mode is already on
			if (test_mode_q && is_read) begin
				sel_q       <= read_sel;
				sel_valid_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Snapshot store; tracking word is passed unchanged as a signed field value
	ssic_value_store u_store (
		.ref_clk         (ref_clk),
		.nrst            (nrst),
		.capture         (capture),
		.min_value       (min_value),
		.max_value       (max_value),
		.threshold_value (threshold_value),
		.tracking_value  (tracking_value),
		.rd_sel          (sel_q),
		.rd_data_q       (rd_data)
	);

	// ==========================================================
	// Open-drain output
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			line_oe          <= 1'b0;
			line_out         <= 1'b0;
			test_mode_active <= 1'b0;
			protocol_error   <= 1'b0;
		end else begin
			if (state_d == ST_ERROR) begin
				line_oe <= 1'b1;
			end else if (state_d == ST_REPLY) begin
				line_oe <= ~(bit_done ? reply_bit : resp_q);
			end else if (sess_q || capture) begin
				line_oe <= 1'b0;
			end else begin
				line_oe <= ~tooth_present;
			end
			line_out         <= 1'b0;
			test_mode_active <= test_mode_q;
			protocol_error   <= (state_d == ST_ERROR);
		end
	end

endmodule

`default_nettype wire

/* verilog/ssic_pkg.sv */
// Constants, types and timing counts for the speed sensor inspection command decoder.
// Assumes a single 50 MHz clock; all counts below are in cycles of that clock.
package ssic_pkg;

	// ==========================================================
	// Clock
	localparam int CLK_PERIOD_NS = 20;

	// ==========================================================
	// Frame layout
	localparam int CMD_BITS  = 8;
	localparam int DATA_BITS = 16;
	localparam int VALUE_W   = 16;
	localparam int CNT_W     = 16;
	localparam int BITCNT_W  = 5;

	// Tracking value is two's complement, full scale spans this many mT each way
	localparam int FIELD_SPAN_MT = 500;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_ACTIVATE = 8'hC5;
	localparam logic [7:0] CMD_READ_MIN = 8'hAC;
	localparam logic [7:0] CMD_READ_MAX = 8'hAD;
	localparam logic [7:0] CMD_READ_THR = 8'hAF;
	localparam logic [7:0] CMD_READ_IIR = 8'hBA;

	// Value store slots
	localparam logic [1:0] SEL_MIN = 2'h0;
	localparam logic [1:0] SEL_MAX = 2'h1;
	localparam logic [1:0] SEL_THR = 2'h2;
	localparam logic [1:0] SEL_IIR = 2'h3;

	// ==========================================================
	// Timing
	localparam int BIT_TIMEOUT_US  = 200;
	localparam int GAP_TIMEOUT_US  = 1000;
	localparam int REPLY_EXTRA_NS  = 1000;
	localparam int BIT_TIMEOUT_CYC = BIT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int GAP_TIMEOUT_CYC = GAP_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
	localparam int REPLY_EXTRA_CYC = REPLY_EXTRA_NS / CLK_PERIOD_NS;

	typedef logic [CNT_W-1:0] ssic_cnt_t;

	// ==========================================================
	// Bit receiver states
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_LOW   = 6'h02,
		ST_HIGH  = 6'h04,
		ST_MARK  = 6'h08,
		ST_REPLY = 6'h10,
		ST_ERROR = 6'h20
	} ssic_state_e;

endpackage

/* verilog/ssic_value_store.sv */
// Four-word snapshot store for the values read over the inspection link.
// Assumes one clock; all four words are written together, read data is registered.
`timescale 1ns/10ps
`default_nettype none

module ssic_value_store (
	input  wire logic                          ref_clk,
	input  wire logic                          nrst,
	input  wire logic                          capture,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  min_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  max_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  threshold_value,
	input  wire logic [ssic_pkg::VALUE_W-1:0]  tracking_value,
	input  wire logic [1:0]                    rd_sel,
	output var  logic [ssic_pkg::VALUE_W-1:0]  rd_data_q
);
	import ssic_pkg::*;

	logic [VALUE_W-1:0] mem_q [4];

	// ==========================================================
	// Storage
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) begin
				mem_q[i] <= 16'h0000;
			end
		end else if (capture) begin
			mem_q[SEL_MIN] <= min_value;
			mem_q[SEL_MAX] <= max_value;
			mem_q[SEL_THR] <= threshold_value;
			mem_q[SEL_IIR] <= tracking_value;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= 16'h0000;
		end else begin
			rd_data_q <= mem_q[rd_sel];
		end
	end

endmodule

`default_nettype wire
